// file: sis_pkg.sv
// Shared constants and types of the supervisor integration shell
package sis_pkg;
  // Register bus address width and register byte offsets
  localparam int unsigned REG_AW        = 8;
  localparam logic [7:0]  OFS_CPU_CTRL  = 8'h00;
  localparam logic [7:0]  OFS_CPU_A31   = 8'h08;
  localparam logic [7:0]  OFS_DBG_A31   = 8'h0C;
  localparam logic [7:0]  OFS_INT_MASK  = 8'h14;
  localparam logic [7:0]  OFS_INT_REQ   = 8'h18;
  localparam logic [7:0]  OFS_RAM_SIZE  = 8'h1C;
  localparam logic [7:0]  OFS_SGI       = 8'h30;
  localparam logic [7:0]  OFS_TRAP_CTRL = 8'h40;
  localparam logic [7:0]  OFS_TRAP_ADDR = 8'h44;
  localparam logic [7:0]  OFS_INT_PEND  = 8'h80;
  localparam logic [7:0]  OFS_BAUD      = 8'h84;
  // Field positions
  localparam int unsigned CTRL_RST_BIT  = 0;
  localparam int unsigned CTRL_BRK_BIT  = 1;
  localparam int unsigned CTRL_PRES_BIT = 31;
  localparam int unsigned TRAP_EN_BIT   = 0;
  localparam int unsigned REQ_VLD_BIT   = 8;
  localparam int unsigned BAUD_LCK_BIT  = 31;
  // Reset values
  localparam logic        RST_CTRL_BRK  = 1'b0;
  localparam logic [7:0]  RST_INT_MASK  = 8'h00;
  localparam logic        RST_TRAP_EN   = 1'b0;
  localparam logic [31:0] RST_TRAP_ADDR = 32'h0000_0000;
  // Interrupt line numbers, lower number wins
  localparam int unsigned IRQ_LINES     = 8;
  localparam int unsigned IRQ_EXT_LINES = 4;
  localparam int unsigned IRQ_BUS_ERR   = 0;
  localparam int unsigned IRQ_TRAP      = 1;
  localparam int unsigned IRQ_SGI       = 2;
  localparam int unsigned IRQ_DMA       = 3;
  localparam int unsigned IRQ_EXT_BASE  = 4;
  // Reset release stages in clock cycles and RAM words per kilobyte
  localparam int unsigned RST_STAGES    = 4;
  localparam int unsigned RAM_WORD_PER_KB = 256;
  // Host bus transaction states
  typedef enum logic [1:0] {ST_IDLE, ST_EXP_REQ, ST_EXP_WAIT, ST_DONE} sis_host_st_t;
endpackage

// file: sis_rst_ctrl.sv
// Reset controller: asynchronous assertion, clocked release
`timescale 1ns/1ps
module sis_rst_ctrl
(
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      sync_rst_n
);
  import sis_pkg::*;

  logic [RST_STAGES-1:0] chain_q;

  // Ones walk in after release, cleared at once by the input
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chain_q <= '0;
    else
      chain_q <= {chain_q[RST_STAGES-2:0], 1'b1};
  end

  assign sync_rst_n = chain_q[RST_STAGES-1];

  chk_rst_assert: assert property (@(posedge pclk) !presetn |-> !sync_rst_n)
    else $error("internal reset not held while input reset active");

  chk_rst_release: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> !sync_rst_n [*4] ##1 sync_rst_n)
    else $error("internal reset release not four cycles after input release");
endmodule

// file: sis_irq_edge.sv
// External interrupt synchronisers and rising-edge detectors
`timescale 1ns/1ps
module sis_irq_edge #(
  parameter int unsigned LINES = 4
) (
  input  wire logic             pclk,
  input  wire logic             rst_n,
  input  wire logic [LINES-1:0] irq_in,
  output logic      [LINES-1:0] irq_pulse
);
  import sis_pkg::*;

  // Two-stage synchroniser, then compare with previous sample
  for (genvar i = 0; i < LINES; i++)
  begin : g_line
    logic meta_q;
    logic sync_q;
    logic last_q;

    always_ff @(posedge pclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
        last_q <= 1'b0;
      end
      else
      begin
        meta_q <= irq_in[i];
        sync_q <= meta_q;
        last_q <= sync_q;
      end
    end

    assign irq_pulse[i] = sync_q && !last_q;

    chk_irq_single: assert property (@(posedge pclk) disable iff (!rst_n)
      irq_pulse[i] |=> !irq_pulse[i])
      else $error("interrupt pulse longer than one cycle");

    chk_irq_edge: assert property (@(posedge pclk) disable iff (!rst_n)
      $rose(irq_in[i]) ##1 irq_in[i] ##1 irq_in[i] |-> irq_pulse[i])
      else $error("held rising interrupt input gave no pulse");
  end
endmodule

// file: sis_shell.sv
// Supervisor integration shell: reset, serial input, host bus, expansion port
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module sis_shell #(
  parameter int unsigned cpu_present            = 1,
  parameter int unsigned cpu_reset_init         = 1,
  parameter int unsigned upper_addr_bit_init    = 1,
  parameter int unsigned ram_capacity_kilobytes = 1,
  parameter string       ram_init_file          = "",
  parameter int unsigned baud_cnt_w             = 16
) (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [sis_pkg::REG_AW-1:0]     paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  output logic                                sync_rst_n,
  input  wire logic                           rx_in,
  output logic                                tx_out,
  input  wire logic                           host_req,
  input  wire logic                           host_we,
  input  wire logic [31:0]                    host_addr,
  input  wire logic [31:0]                    host_wdata,
  output logic                                host_resp,
  output logic      [31:0]                    host_rdata,
  output logic                                exp_req,
  output logic                                exp_we,
  output logic      [31:0]                    exp_addr,
  output logic      [31:0]                    exp_wdata,
  input  wire logic                           exp_ack,
  input  wire logic                           exp_resp,
  input  wire logic [31:0]                    exp_rdata,
  input  wire logic [sis_pkg::IRQ_EXT_LINES-1:0] ext_irq,
  input  wire logic                           dma_done,
  output logic                                cpu_rst,
  output logic                                cpu_break,
  output logic                                cpu_irq,
  output logic      [2:0]                     cpu_irq_num
);
  import sis_pkg::*;

  localparam int unsigned RAM_WORDS = ram_capacity_kilobytes * RAM_WORD_PER_KB;
  localparam int unsigned RAM_IW    = $clog2(RAM_WORDS);
  localparam logic [31:0] RAM_BYTES = 32'(RAM_WORDS * 4);
  localparam logic        CPU_RST_INIT = (cpu_present == 0) || (cpu_reset_init != 0);
  localparam logic        A31_INIT     = (upper_addr_bit_init != 0);

  logic                     rst_n;
  logic                     pready_q;
  logic                     pslverr_q;
  logic [31:0]              prdata_q;
  logic                     ctrl_rst_q;
  logic                     ctrl_brk_q;
  logic                     cpu_a31_q;
  logic                     dbg_a31_q;
  logic [IRQ_LINES-1:0]     mask_q;
  logic [IRQ_LINES-1:0]     pend_q;
  logic                     trap_en_q;
  logic [31:0]              trap_addr_q;
  logic                     cpu_irq_q;
  logic [2:0]               irq_num_q;
  sis_host_st_t             state_q;
  logic                     host_resp_q;
  logic [31:0]              host_rdata_q;
  logic                     exp_req_q;
  logic                     exp_we_q;
  logic [31:0]              exp_addr_q;
  logic [31:0]              exp_wdata_q;
  logic [31:0]              ram_q [RAM_WORDS];
  logic                     rx_q;
  logic                     rx_prev_q;
  logic                     meas_q;
  logic                     lock_q;
  logic [baud_cnt_w-1:0]    cnt_q;
  logic [baud_cnt_w-1:0]    baud_q;
  logic                     tx_q;
  logic                     apb_acc;
  logic                     apb_wr;
  logic                     reg_hit;
  logic [31:0]              reg_rd;
  logic                     host_take;
  logic                     host_in_ram;
  logic [RAM_IW-1:0]        ram_idx;
  logic [IRQ_EXT_LINES-1:0] ext_pulse;
  logic [IRQ_LINES-1:0]     pend_set;
  logic [IRQ_LINES-1:0]     pend_clr;
  logic                     irq_hit;
  logic [2:0]               irq_sel;

  // Reset controller drives every register except the RAM, and the reset output
  sis_rst_ctrl u_rst (
    .pclk       (pclk),
    .presetn    (presetn),
    .sync_rst_n (rst_n)
  );

  // External interrupt conditioning
  sis_irq_edge #(
    .LINES (IRQ_EXT_LINES)
  ) u_irq (
    .pclk      (pclk),
    .rst_n     (rst_n),
    .irq_in    (ext_irq),
    .irq_pulse (ext_pulse)
  );

  // Output ports straight from flops
  assign sync_rst_n  = rst_n;
  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign tx_out      = tx_q;
  assign host_resp   = host_resp_q;
  assign host_rdata  = host_rdata_q;
  assign exp_req     = exp_req_q;
  assign exp_we      = exp_we_q;
  assign exp_addr    = exp_addr_q;
  assign exp_wdata   = exp_wdata_q;
  assign cpu_rst     = ctrl_rst_q;
  assign cpu_break   = ctrl_brk_q;
  assign cpu_irq     = cpu_irq_q;
  assign cpu_irq_num = irq_num_q;

  // APB strobes: answer one cycle after access, write on the pready edge
  assign apb_acc = psel && penable && !pready_q;
  assign apb_wr  = psel && penable && pready_q && pwrite;

  // Register read decode
  always_comb
  begin
    reg_hit = 1'b1;
    reg_rd  = '0;
    case (paddr)
      OFS_CPU_CTRL:
      begin
        reg_rd[CTRL_RST_BIT]  = ctrl_rst_q;
        reg_rd[CTRL_BRK_BIT]  = ctrl_brk_q;
        reg_rd[CTRL_PRES_BIT] = (cpu_present != 0);
      end
      OFS_CPU_A31:   reg_rd[0] = cpu_a31_q;
      OFS_DBG_A31:   reg_rd[0] = dbg_a31_q;
      OFS_INT_MASK:  reg_rd[IRQ_LINES-1:0] = mask_q;
      OFS_INT_REQ:   reg_rd[REQ_VLD_BIT:0] = {cpu_irq_q, 5'h00, irq_num_q};
      OFS_RAM_SIZE:  reg_rd = 32'(ram_capacity_kilobytes);
      OFS_SGI:       reg_rd = '0;
      OFS_TRAP_CTRL: reg_rd[TRAP_EN_BIT] = trap_en_q;
      OFS_TRAP_ADDR: reg_rd = trap_addr_q;
      OFS_INT_PEND:  reg_rd[IRQ_LINES-1:0] = pend_q;
      OFS_BAUD:
      begin
        reg_rd[baud_cnt_w-1:0] = baud_q;
        reg_rd[BAUD_LCK_BIT]   = lock_q;
      end
      default:       reg_hit = 1'b0;
    endcase
  end

  // APB answer: ready, error on unmapped offset, read data
  always_ff @(posedge pclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end
    else
    begin
      pready_q  <= apb_acc;
      pslverr_q <= apb_acc && !reg_hit;
      prdata_q  <= apb_acc ? reg_rd : '0;
    end
  end

  // Control registers written by software
  always_ff @(posedge pclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_rst_q  <= CPU_RST_INIT;
      ctrl_brk_q  <= RST_CTRL_BRK;
      cpu_a31_q   <= A31_INIT;
      dbg_a31_q   <= A31_INIT;
      mask_q      <= RST_INT_MASK;
      trap_en_q   <= RST_TRAP_EN;
      trap_addr_q <= RST_TRAP_ADDR;
    end
    else if (apb_wr)
    begin
      case (paddr)
        OFS_CPU_CTRL:
        begin
          ctrl_rst_q <= pwdata[CTRL_RST_BIT] || (cpu_present == 0);
          ctrl_brk_q <= pwdata[CTRL_BRK_BIT];
        end
        OFS_CPU_A31:   cpu_a31_q   <= pwdata[0];
        OFS_DBG_A31:   dbg_a31_q   <= pwdata[0];
        OFS_INT_MASK:  mask_q      <= pwdata[IRQ_LINES-1:0];
        OFS_TRAP_CTRL: trap_en_q   <= pwdata[TRAP_EN_BIT];
        OFS_TRAP_ADDR: trap_addr_q <= pwdata;
        default:       trap_en_q   <= trap_en_q;
      endcase
    end
  end

  // Host request decode: top bit selects expansion, else RAM or bus error
  assign host_take   = (state_q == ST_IDLE) && host_req;
  assign host_in_ram = !host_addr[31] && (host_addr < RAM_BYTES);
  assign ram_idx     = host_addr[RAM_IW+1:2];

  // Interrupt events: internal sources low numbers, external above
  always_comb
  begin
    pend_set               = '0;
    pend_set[IRQ_BUS_ERR]  = host_take && !host_addr[31] && !host_in_ram;
    pend_set[IRQ_TRAP]     = host_take && trap_en_q && (host_addr == trap_addr_q);
    pend_set[IRQ_SGI]      = apb_wr && (paddr == OFS_SGI) && !pwdata[0];
    pend_set[IRQ_DMA]      = dma_done;
    pend_set[IRQ_LINES-1:IRQ_EXT_BASE] = ext_pulse;
    pend_clr = (apb_wr && (paddr == OFS_INT_REQ)) ? pwdata[IRQ_LINES-1:0] : '0;
  end

  // Sticky pending bits, set wins over a same-cycle clear
  always_ff @(posedge pclk or negedge rst_n)
  begin
    if (!rst_n)
      pend_q <= '0;
    else
      pend_q <= (pend_q & ~pend_clr) | pend_set;
  end

  // Lowest enabled pending number wins
  always_comb
  begin
    irq_hit = 1'b0;
    irq_sel = '0;
    for (int i = IRQ_LINES - 1; i >= 0; i--)
    begin
      if (pend_q[i] && mask_q[i])
      begin
        irq_hit = 1'b1;
        irq_sel = 3'(i);
      end
    end
  end

  // Interrupt request to the processor
  always_ff @(posedge pclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_irq_q <= 1'b0;
      irq_num_q <= '0;
    end
    else
    begin
      cpu_irq_q <= irq_hit && (cpu_present != 0);
      irq_num_q <= irq_sel;
    end
  end

  // Host transaction sequencer and expansion master
  always_ff @(posedge pclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q      <= ST_IDLE;
      host_resp_q  <= 1'b0;
      host_rdata_q <= '0;
      exp_req_q    <= 1'b0;
      exp_we_q     <= 1'b0;
      exp_addr_q   <= '0;
      exp_wdata_q  <= '0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (host_take && host_addr[31])
          begin
            exp_req_q   <= 1'b1;
            exp_we_q    <= host_we;
            exp_addr_q  <= {dbg_a31_q, host_addr[30:0]};
            exp_wdata_q <= host_wdata;
            state_q     <= ST_EXP_REQ;
          end
          else if (host_take)
          begin
            host_resp_q  <= 1'b1;
            host_rdata_q <= (host_in_ram && !host_we) ? ram_q[ram_idx] : '0;
            state_q      <= ST_DONE;
          end
        end
        ST_EXP_REQ:
        begin
          if (exp_ack)
          begin
            exp_req_q <= 1'b0;
            if (exp_we_q)
            begin
              host_resp_q <= 1'b1;
              state_q     <= ST_DONE;
            end
            else
              state_q <= ST_EXP_WAIT;
          end
        end
        ST_EXP_WAIT:
        begin
          // One read outstanding, so responses keep request order
          if (exp_resp)
          begin
            host_resp_q  <= 1'b1;
            host_rdata_q <= exp_rdata;
            state_q      <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          host_resp_q <= 1'b0;
          state_q     <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Embedded RAM, word addressed, written on accepted host write requests
  always_ff @(posedge pclk)
  begin
    if (host_take && host_in_ram && host_we)
      ram_q[ram_idx] <= host_wdata;
  end

  // Serial input register and baud measurement on the first low bit
  always_ff @(posedge pclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_q      <= 1'b1;
      rx_prev_q <= 1'b1;
      meas_q    <= 1'b0;
      lock_q    <= 1'b0;
      cnt_q     <= '0;
      baud_q    <= '0;
      tx_q      <= 1'b1;
    end
    else
    begin
      rx_q      <= rx_in;
      rx_prev_q <= rx_q;
      if (!lock_q && !meas_q && rx_prev_q && !rx_q)
      begin
        meas_q <= 1'b1;
        cnt_q  <= {{(baud_cnt_w-1){1'b0}}, 1'b1};
      end
      else if (meas_q && rx_q)
      begin
        meas_q <= 1'b0;
        lock_q <= 1'b1;
        baud_q <= cnt_q;
      end
      else if (meas_q && (cnt_q != '1))
        cnt_q <= cnt_q + 1'b1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!rst_n);

  sequence s_rd_accept;
    (state_q == ST_EXP_REQ) && exp_ack && !exp_we_q;
  endsequence

  sequence s_rd_return;
    (state_q == ST_EXP_WAIT) && exp_resp;
  endsequence

  chk_host_resp_pulse: assert property (host_resp_q |=> !host_resp_q)
    else $error("host response longer than one cycle");

  chk_exp_req_hold: assert property (exp_req_q && !exp_ack
    |=> exp_req_q && $stable(exp_addr_q))
    else $error("expansion request dropped before acknowledge");

  chk_exp_wr_done: assert property (exp_req_q && exp_ack && exp_we_q
    |=> host_resp_q && !exp_req_q)
    else $error("expansion write not finished on acknowledge");

  chk_exp_rd_wait: assert property (s_rd_accept |=> !host_resp_q && (state_q == ST_EXP_WAIT))
    else $error("expansion read did not wait for response");

  chk_exp_rd_data: assert property (s_rd_return
    |=> host_resp_q && host_rdata_q == $past(exp_rdata))
    else $error("expansion read data not returned to host");

  chk_a31_route: assert property ($rose(exp_req_q) |-> exp_addr_q[31] == dbg_a31_q)
    else $error("expansion top address bit not from its register");

  chk_rx_reg: assert property (##1 rx_q == $past(rx_in))
    else $error("serial input not registered");

  chk_baud_lock: assert property (meas_q && rx_q |=> lock_q && baud_q == $past(cnt_q))
    else $error("baud period not captured at end of start bit");

  chk_cpu_absent: assert property ((cpu_present == 0) |-> cpu_rst && !cpu_irq)
    else $error("absent processor not held in reset");

  chk_pend_set_wins: assert property ((pend_set & pend_clr) != '0
    |=> (pend_q & $past(pend_set) & $past(pend_clr)) == ($past(pend_set) & $past(pend_clr)))
    else $error("interrupt event lost to a same-cycle clear");
endmodule

// file: sis_exp_slave.sv
// Expansion-port slave model with settable answer latency
`timescale 1ns/1ps
module sis_exp_slave (
  input  wire logic        pclk,
  input  wire logic        exp_req,
  input  wire logic        exp_we,
  input  wire logic [31:0] exp_addr,
  input  wire logic [31:0] exp_wdata,
  input  wire logic [3:0]  lat,
  output logic             exp_ack,
  output logic             exp_resp,
  output logic      [31:0] exp_rdata,
  output logic      [31:0] seen_addr
);
  logic [31:0] mem [4];
  logic        wr;
  // One request at a time, read answers in order
  initial
  begin
    exp_ack = 1'b0;
    exp_resp = 1'b0;
    exp_rdata = 32'hA5A5_5A5A;
    seen_addr = 32'h0;
    forever
    begin
      @(posedge pclk);
      if (exp_req === 1'b1)
      begin
        repeat (lat) @(posedge pclk);
        wr = exp_we;
        seen_addr <= exp_addr;
        if (wr) mem[exp_addr[3:2]] <= exp_wdata;
        exp_ack <= 1'b1;
        @(posedge pclk) exp_ack <= 1'b0;
        if (!wr)
        begin
          repeat (lat) @(posedge pclk);
          exp_resp <= 1'b1;
          exp_rdata <= mem[seen_addr[3:2]];
          @(posedge pclk) exp_resp <= 1'b0;
          exp_rdata <= ~exp_rdata; // No stale data left
        end
      end
    end
  end
endmodule

// file: sis_shell_test.sv
// Self-checking bench of the supervisor integration shell
`timescale 1ns/1ps
module sis_shell_test;
  import sis_pkg::*;
  logic                     pclk, presetn, psel, penable, pwrite, rx_in, err;
  logic [REG_AW-1:0]        paddr;
  logic [31:0]              pwdata, prdata, host_addr, host_wdata, host_rdata, rd;
  logic [31:0]              exp_addr, exp_wdata, exp_rdata, seen_addr;
  logic                     pready, pslverr, sync_rst_n, tx_out, host_req, host_we;
  logic                     host_resp, exp_req, exp_we, exp_ack, exp_resp, dma_done;
  logic                     cpu_rst, cpu_break, cpu_irq;
  logic [2:0]               cpu_irq_num;
  logic [IRQ_EXT_LINES-1:0] ext_irq;
  logic [3:0]               lat;
  int                       n_mismatch = 0;
  int                       cmp_count = 0;
  logic [7:0]  ofs [5] = '{OFS_CPU_CTRL, OFS_CPU_A31, OFS_DBG_A31, OFS_RAM_SIZE, OFS_INT_MASK};
  logic [31:0] rv [5] = '{32'h8000_0001, 32'h1, 32'h1, 32'h1, 32'h0};
  // Design and far-side model
  sis_shell u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sync_rst_n, .rx_in, .tx_out, .host_req, .host_we, .host_addr,
    .host_wdata, .host_resp, .host_rdata, .exp_req, .exp_we, .exp_addr, .exp_wdata,
    .exp_ack, .exp_resp, .exp_rdata, .ext_irq, .dma_done, .cpu_rst, .cpu_break,
    .cpu_irq, .cpu_irq_num
  );
  sis_exp_slave u_slv (
    .pclk, .exp_req, .exp_we, .exp_addr, .exp_wdata, .lat, .exp_ack, .exp_resp,
    .exp_rdata, .seen_addr
  );
  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // APB transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Host bus transfer, request held until response
  task automatic host(input logic w, input logic [31:0] a, input logic [31:0] d);
    host_req <= 1'b1;
    host_we <= w;
    host_addr <= a;
    host_wdata <= d;
    do
    begin
      @(posedge pclk);
    end
    while (host_resp !== 1'b1);
    rd = host_rdata;
    host_req <= 1'b0;
    @(posedge pclk);
  endtask
  // Reset held two cycles, then release
  task automatic reset_seq();
    repeat (2) @(posedge pclk);
    chk("sync_rst_n low", sync_rst_n, 1'b0);
    chk("cpu_rst", {cpu_rst, cpu_break}, 2'b10);
    chk("tx idle", tx_out, 1'b1);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("sync_rst_n held", sync_rst_n, 1'b0);
    repeat (2) @(posedge pclk);
    chk("sync_rst_n up", sync_rst_n, 1'b1);
  endtask
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, host_req, host_we, dma_done} = '0;
    presetn <= 1'b0;
    {paddr, pwdata, host_addr, host_wdata, ext_irq, lat} = '0;
    rx_in = 1'b1;
    reset_seq();
    rx_in <= 1'b0;
    repeat (20) @(posedge pclk);
    rx_in <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_BAUD, 32'h0);
    chk("baud", rd, 32'h8000_0014);
    foreach (ofs[i])
    begin
      apb(1'b0, ofs[i], 32'h0);
      chk("reset value", rd, rv[i]);
    end
    apb(1'b0, 8'h04, 32'h0);
    chk("unmapped", err, 1'b1);
    host(1'b1, 32'h0000_0010, 32'hCAFE_0123);
    host(1'b0, 32'h0000_0010, 32'h0);
    chk("ram read", rd, 32'hCAFE_0123);
    host(1'b1, 32'h8000_0004, 32'h1234_5678);
    chk("exp addr", seen_addr, 32'h8000_0004);
    lat <= 4'd3;
    host(1'b0, 32'h8000_0004, 32'h0);
    chk("exp read", rd, 32'h1234_5678);
    apb(1'b1, OFS_DBG_A31, 32'h0);
    host(1'b1, 32'h8000_0008, 32'h0BAD_F00D);
    chk("exp msb", seen_addr, 32'h0000_0008);
    host(1'b0, 32'h8000_0008, 32'h0);
    chk("exp read 2", rd, 32'h0BAD_F00D);
    host(1'b0, 32'h0000_0400, 32'h0);
    chk("bus err data", rd, 32'h0);
    apb(1'b0, OFS_INT_PEND, 32'h0);
    chk("bus err pend", rd, 32'h1);
    apb(1'b1, OFS_INT_REQ, 32'hFF);
    ext_irq <= 4'b0110;
    repeat (6) @(posedge pclk);
    apb(1'b0, OFS_INT_PEND, 32'h0);
    chk("ext pend", rd, 32'h60);
    apb(1'b1, OFS_INT_MASK, 32'hF0);
    apb(1'b0, OFS_INT_REQ, 32'h0);
    chk("ext number", rd, 32'h105);
    chk("irq pin ext", {cpu_irq, cpu_irq_num}, 4'hD);
    apb(1'b1, OFS_INT_REQ, 32'hFF);
    repeat (6) @(posedge pclk);
    apb(1'b0, OFS_INT_PEND, 32'h0);
    chk("level held", rd, 32'h0);
    dma_done <= 1'b1;
    @(posedge pclk);
    dma_done <= 1'b0;
    apb(1'b1, OFS_INT_MASK, 32'hFF);
    apb(1'b0, OFS_INT_REQ, 32'h0);
    chk("dma number", rd, 32'h103);
    chk("irq pin dma", {cpu_irq, cpu_irq_num}, 4'hB);
    apb(1'b1, OFS_INT_REQ, 32'hFF);
    apb(1'b1, OFS_SGI, 32'h0);
    apb(1'b1, OFS_TRAP_ADDR, 32'h0000_0020);
    apb(1'b1, OFS_TRAP_CTRL, 32'h1);
    host(1'b0, 32'h0000_0020, 32'h0);
    apb(1'b0, OFS_INT_PEND, 32'h0);
    chk("sgi trap pend", rd, 32'h6);
    apb(1'b1, OFS_CPU_CTRL, 32'h2);
    chk("cpu pins", {cpu_rst, cpu_break}, 2'b01);
    apb(1'b0, OFS_CPU_CTRL, 32'h0);
    chk("ctrl back", rd, 32'h8000_0002);
    presetn <= 1'b0;
    #1;
    chk("async assert", sync_rst_n, 1'b0);
    @(posedge pclk);
    reset_seq();
    finish_test();
  end
  // Watchdog
  initial
  begin
    #100us;
    n_mismatch++;
    finish_test();
  end
endmodule
